// file: rtl/fec_mon_defines.svh
// Register offsets, reset values and timing counts of the FEC error monitor registers
`ifndef FEC_MON_DEFINES_SVH
`define FEC_MON_DEFINES_SVH
`define ADDR_SOFT_RESET      8'h00
`define ADDR_VSB_BYTE0       8'h1b
`define ADDR_VSB_BYTE1       8'h1c
`define ADDR_VSB_BYTE2       8'h1d
`define ADDR_QAM_BYTE0       8'h1e
`define ADDR_QAM_BYTE1       8'h1f
`define ADDR_QAM_BYTE2       8'h20
`define ADDR_THR_LOW         8'h21
`define ADDR_THR_HIGH        8'h22
`define ADDR_SNAP_CTRL       8'h25
`define ADDR_RX_STATUS       8'h26
`define RST_VSB_BYTE0        8'hbc
`define RST_VSB_BYTE1        8'h64
`define RST_VSB_BYTE2        8'h00
`define RST_QAM_BYTE0        8'h00
`define RST_QAM_BYTE1        8'h08
`define RST_QAM_BYTE2        8'h00
`define RST_THR_LOW          8'h05
`define RST_THR_HIGH         4'h0
`define SNAP_BIT             0
`define OVER_THR_BIT         3
`define SNAP_CYCLES          4'h4
`endif

// file: rtl/fec_mon_pkg.sv
// Types shared by the FEC error monitor register bank
package fec_mon_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;
   typedef struct packed {
      logic [23:0] vsb_interval;
      logic [23:0] qam_interval;
      logic [11:0] threshold;
   } mon_cfg_t;
   typedef enum logic [0:0] {SNAP_IDLE, SNAP_BUSY} snap_state_t;
endpackage : fec_mon_pkg

// file: rtl/fec_error_monitor_regs.sv
// FEC error monitor configuration and status snapshot register bank
//
// Overview of operation
// - VSB interval byte 2 at 1Dh, resets zero
// - QAM interval bytes at 1Eh, 1Fh, 20h
// - QAM interval resets to 2048 blocks
// - New settings apply only after soft reset
// - Threshold low byte at 21h, resets five
// - Threshold high nibble at 22h, upper zero
// - Writing update bit when idle captures all status
// - Update bit reads one until capture done
// - Control bits 7:1 read zero, reset zero
// - VSB interval bytes 0,1 at 1Bh, 1Ch
// - Status bit shows errors above threshold
`timescale 1ns/1ps
`default_nettype none
`include "fec_mon_defines.svh"
module fec_error_monitor_regs
(
   // Clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  resetn_in,
   // Register port
   input  wire fec_mon_pkg::reg_req_t req_in,
   output logic [7:0]                 rdata_out,
   // FEC side
   input  wire logic                  qam_mode_in,
   input  wire logic                  rs_block_in,
   input  wire logic                  seg_error_in,
   output fec_mon_pkg::mon_cfg_t      active_cfg_out,
   output logic                       soft_reset_out,
   output logic                       snapshot_out
);
   import fec_mon_pkg::*;

   // ***********************************************
   // Registers
   // ***********************************************
   logic [7:0]  vsb0_reg, vsb0_next, vsb1_reg, vsb1_next, vsb2_reg, vsb2_next;
   logic [7:0]  qam0_reg, qam0_next, qam1_reg, qam1_next, qam2_reg, qam2_next;
   logic [7:0]  thr_lo_reg, thr_lo_next;
   logic [3:0]  thr_hi_reg, thr_hi_next;
   mon_cfg_t    cfg_reg, cfg_next;
   logic        srst_reg, srst_next;
   snap_state_t snap_reg, snap_next;
   logic [3:0]  snap_cnt_reg, snap_cnt_next;
   logic        snap_pulse_reg, snap_pulse_next;
   logic [23:0] blk_cnt_reg, blk_cnt_next;
   logic [11:0] err_cnt_reg, err_cnt_next;
   logic        over_reg, over_next;
   logic        over_snap_reg, over_snap_next;
   logic [7:0]  rdata_reg, rdata_next;

   function automatic logic [11:0] sat_inc(input logic [11:0] v);
      sat_inc = (v == 12'hfff) ? v : v + 12'h001;
   endfunction : sat_inc

   logic [23:0] interval;
   logic        int_end;
   assign interval = qam_mode_in ? cfg_reg.qam_interval : cfg_reg.vsb_interval;
   assign int_end  = rs_block_in && (blk_cnt_reg + 24'h000001 >= interval);

   // ***********************************************
   // Next state
   // ***********************************************
   always_comb
   begin
      vsb0_next = vsb0_reg;
      vsb1_next = vsb1_reg;
      vsb2_next = vsb2_reg;
      qam0_next = qam0_reg;
      qam1_next = qam1_reg;
      qam2_next = qam2_reg;
      thr_lo_next = thr_lo_reg;
      thr_hi_next = thr_hi_reg;
      cfg_next = cfg_reg;
      srst_next = 1'b0;
      snap_next = snap_reg;
      snap_cnt_next = snap_cnt_reg;
      snap_pulse_next = 1'b0;
      blk_cnt_next = blk_cnt_reg;
      err_cnt_next = err_cnt_reg;
      over_next = over_reg;
      over_snap_next = over_snap_reg;
      rdata_next = 8'h00;
      if (req_in.wr)
      begin
         if (req_in.addr == `ADDR_SOFT_RESET)
            srst_next = 1'b1;
         else if (req_in.addr == `ADDR_VSB_BYTE0)
            vsb0_next = req_in.wdata;
         else if (req_in.addr == `ADDR_VSB_BYTE1)
            vsb1_next = req_in.wdata;
         else if (req_in.addr == `ADDR_VSB_BYTE2)
            vsb2_next = req_in.wdata;
         else if (req_in.addr == `ADDR_QAM_BYTE0)
            qam0_next = req_in.wdata;
         else if (req_in.addr == `ADDR_QAM_BYTE1)
            qam1_next = req_in.wdata;
         else if (req_in.addr == `ADDR_QAM_BYTE2)
            qam2_next = req_in.wdata;
         else if (req_in.addr == `ADDR_THR_LOW)
            thr_lo_next = req_in.wdata;
         else if (req_in.addr == `ADDR_THR_HIGH)
            thr_hi_next = req_in.wdata[3:0];
      end
      // Soft reset loads the shadow copies and restarts counting
      if (srst_reg)
      begin
         cfg_next.vsb_interval = {vsb2_reg, vsb1_reg, vsb0_reg};
         cfg_next.qam_interval = {qam2_reg, qam1_reg, qam0_reg};
         cfg_next.threshold = {thr_hi_reg, thr_lo_reg};
         blk_cnt_next = 24'h000000;
         err_cnt_next = 12'h000;
      end
      else
      begin
         if (int_end)
         begin
            // Error on the last block still counts toward this interval
            over_next = ((seg_error_in ? sat_inc(err_cnt_reg) : err_cnt_reg)
                         > cfg_reg.threshold);
            blk_cnt_next = 24'h000000;
            err_cnt_next = 12'h000;
         end
         else
         begin
            if (rs_block_in)
               blk_cnt_next = blk_cnt_reg + 24'h000001;
            if (seg_error_in)
               err_cnt_next = sat_inc(err_cnt_reg);
         end
      end
      case (snap_reg)
         SNAP_IDLE:
         begin
            if (req_in.wr && req_in.addr == `ADDR_SNAP_CTRL && req_in.wdata[`SNAP_BIT])
            begin
               snap_next = SNAP_BUSY;
               snap_cnt_next = `SNAP_CYCLES;
               snap_pulse_next = 1'b1;
               over_snap_next = over_reg;
            end
         end
         SNAP_BUSY:
         begin
            // Held busy a few cycles so downstream status captures settle
            if (snap_cnt_reg == 4'h1)
               snap_next = SNAP_IDLE;
            snap_cnt_next = snap_cnt_reg - 4'h1;
         end
         default:
            snap_next = SNAP_IDLE;
      endcase
      if (req_in.rd)
      begin
         if (req_in.addr == `ADDR_VSB_BYTE0)
            rdata_next = vsb0_reg;
         else if (req_in.addr == `ADDR_VSB_BYTE1)
            rdata_next = vsb1_reg;
         else if (req_in.addr == `ADDR_VSB_BYTE2)
            rdata_next = vsb2_reg;
         else if (req_in.addr == `ADDR_QAM_BYTE0)
            rdata_next = qam0_reg;
         else if (req_in.addr == `ADDR_QAM_BYTE1)
            rdata_next = qam1_reg;
         else if (req_in.addr == `ADDR_QAM_BYTE2)
            rdata_next = qam2_reg;
         else if (req_in.addr == `ADDR_THR_LOW)
            rdata_next = thr_lo_reg;
         else if (req_in.addr == `ADDR_THR_HIGH)
            rdata_next = {4'h0, thr_hi_reg};
         else if (req_in.addr == `ADDR_SNAP_CTRL)
            rdata_next = {7'h00, snap_reg == SNAP_BUSY};
         else if (req_in.addr == `ADDR_RX_STATUS)
            rdata_next = {4'h0, over_snap_reg, 3'h0};
      end
   end

   // ***********************************************
   // State registers
   // ***********************************************
   always_ff @(posedge clk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         vsb0_reg <= `RST_VSB_BYTE0;
         vsb1_reg <= `RST_VSB_BYTE1;
         vsb2_reg <= `RST_VSB_BYTE2;
         qam0_reg <= `RST_QAM_BYTE0;
         qam1_reg <= `RST_QAM_BYTE1;
         qam2_reg <= `RST_QAM_BYTE2;
         thr_lo_reg <= `RST_THR_LOW;
         thr_hi_reg <= `RST_THR_HIGH;
         cfg_reg.vsb_interval <= {`RST_VSB_BYTE2, `RST_VSB_BYTE1, `RST_VSB_BYTE0};
         cfg_reg.qam_interval <= {`RST_QAM_BYTE2, `RST_QAM_BYTE1, `RST_QAM_BYTE0};
         cfg_reg.threshold <= {`RST_THR_HIGH, `RST_THR_LOW};
         srst_reg <= 1'b0;
         snap_reg <= SNAP_IDLE;
         snap_cnt_reg <= 4'h0;
         snap_pulse_reg <= 1'b0;
         blk_cnt_reg <= 24'h000000;
         err_cnt_reg <= 12'h000;
         over_reg <= 1'b0;
         over_snap_reg <= 1'b0;
         rdata_reg <= 8'h00;
      end
      else
      begin
         vsb0_reg <= vsb0_next;
         vsb1_reg <= vsb1_next;
         vsb2_reg <= vsb2_next;
         qam0_reg <= qam0_next;
         qam1_reg <= qam1_next;
         qam2_reg <= qam2_next;
         thr_lo_reg <= thr_lo_next;
         thr_hi_reg <= thr_hi_next;
         cfg_reg <= cfg_next;
         srst_reg <= srst_next;
         snap_reg <= snap_next;
         snap_cnt_reg <= snap_cnt_next;
         snap_pulse_reg <= snap_pulse_next;
         blk_cnt_reg <= blk_cnt_next;
         err_cnt_reg <= err_cnt_next;
         over_reg <= over_next;
         over_snap_reg <= over_snap_next;
         rdata_reg <= rdata_next;
      end
   end

   assign rdata_out = rdata_reg;
   assign active_cfg_out = cfg_reg;
   assign soft_reset_out = srst_reg;
   assign snapshot_out = snap_pulse_reg;
endmodule : fec_error_monitor_regs
`default_nettype wire

// file: testbench/fec_mon_props.sv
// Port assertions for the FEC error monitor register bank
`timescale 1ns/1ps
`default_nettype none
module fec_mon_props
(
   input wire logic                  clk_in,
   input wire logic                  resetn_in,
   input wire fec_mon_pkg::reg_req_t req_in,
   input wire logic [7:0]            rdata_out,
   input wire fec_mon_pkg::mon_cfg_t active_cfg_out,
   input wire logic                  soft_reset_out,
   input wire logic                  snapshot_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!resetn_in);
   sequence s_rd(logic [7:0] a); req_in.rd && req_in.addr == a; endsequence
   property p_srst; soft_reset_out == $past(req_in.wr && req_in.addr == 8'h00); endproperty
   a_srst: assert property (p_srst) else $error("soft reset pulse");
   property p_hold; !soft_reset_out |=> $stable(active_cfg_out); endproperty
   a_hold: assert property (p_hold) else $error("cfg moved");
   property p_snap; snapshot_out |-> $past(req_in.wr && req_in.addr == 8'h25 && req_in.wdata[0]); endproperty
   a_snap: assert property (p_snap) else $error("stray snapshot");
   property p_once; snapshot_out |=> !snapshot_out [*4]; endproperty
   a_once: assert property (p_once) else $error("snapshot repeated");
   property p_busy; snapshot_out ##[0:3] s_rd(8'h25) |=> rdata_out == 8'h01; endproperty
   a_busy: assert property (p_busy) else $error("busy not seen");
   property p_done; snapshot_out ##4 s_rd(8'h25) |=> rdata_out == 8'h00; endproperty
   a_done: assert property (p_done) else $error("busy too long");
   property p_idle; !req_in.rd |=> rdata_out == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data stuck");
   property p_thr; s_rd(8'h22) |=> rdata_out[7:4] == 4'h0; endproperty
   a_thr: assert property (p_thr) else $error("threshold upper bits");
   property p_ctl; s_rd(8'h25) |=> rdata_out[7:1] == 7'h00; endproperty
   a_ctl: assert property (p_ctl) else $error("control upper bits");
endmodule : fec_mon_props
bind fec_error_monitor_regs fec_mon_props chk_u (.clk_in, .resetn_in, .req_in, .rdata_out,
   .active_cfg_out, .soft_reset_out, .snapshot_out);
`default_nettype wire

// file: testbench/fec_host_model.sv
// Host processor model for the register port
`timescale 1ns/1ps
`default_nettype none
module fec_host_model
(
   // Register port
   input  wire logic                  clk_in,
   output var fec_mon_pkg::reg_req_t  req_out,
   input  wire logic [7:0]            rdata_in
);
   import fec_mon_pkg::*;
   initial req_out = '0;
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_in);
      req_out = '{1'b1, 1'b0, a, d};
      @(negedge clk_in);
      req_out.wr = 1'b0;
   endtask : wr
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_in);
      req_out = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk_in);
      // Read data stands for one cycle only, so take it here
      d = rdata_in;
      req_out.rd = 1'b0;
   endtask : rd
   // Any write to 00h applies the staged settings
   task soft_reset;
      wr(8'h00, 8'h00);
   endtask : soft_reset
   // Status must not be read before the update bit clears
   task poll;
      logic [7:0] d;
      wr(8'h25, 8'h01);
      d = 8'h01;
      for (int n = 0; n < 16 && d[0] !== 1'b0; n++)
         rd(8'h25, d);
   endtask : poll
endmodule : fec_host_model
`default_nettype wire

// file: testbench/fec_error_monitor_regs_tb.sv
// Self-checking bench for the FEC error monitor register bank
`timescale 1ns/1ps
`default_nettype none
module fec_error_monitor_regs_tb;
   import fec_mon_pkg::*;
   logic       clk_in = 1'b0;
   logic       resetn_in = 1'b0;
   logic       qam_mode_in = 1'b0;
   logic       rs_block_in = 1'b0;
   logic       seg_error_in = 1'b0;
   reg_req_t   req_in;
   logic [7:0] rdata_out;
   mon_cfg_t   active_cfg_out;
   logic       soft_reset_out;
   logic       snapshot_out;
   logic [7:0] d;
   int         bad_count = 0;
   int         checks = 0;
   logic [7:0] a [10] = '{8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h25, 8'h23};
   always #50 clk_in = ~clk_in;
   fec_error_monitor_regs dut_u (.clk_in, .resetn_in, .req_in, .rdata_out, .qam_mode_in,
      .rs_block_in, .seg_error_in, .active_cfg_out, .soft_reset_out, .snapshot_out);
   fec_host_model host_u (.clk_in, .req_out(req_in), .rdata_in(rdata_out));
   task cmp(input string n, input logic [59:0] e, input logic [59:0] g);
      checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : cmp
   task tally_and_finish;
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // ************************************
   // Scenarios
   // ************************************
   task t_reset;
      logic [7:0] e [10] = '{8'hbc, 8'h64, 8'h00, 8'h00, 8'h08, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00};
      cmp("cfg", {24'h0064bc, 24'h000800, 12'h005}, active_cfg_out);
      foreach (a[i])
      begin
         host_u.rd(a[i], d);
         cmp("reset value", e[i], d);
      end
   endtask : t_reset
   // Read-only bits and the unmapped 23h must drop the written ones
   task t_write;
      foreach (a[i])
         host_u.wr(a[i], 8'hfe);
      foreach (a[i])
      begin
         host_u.rd(a[i], d);
         cmp("readback", a[i] == 8'h22 ? 8'h0e : a[i] > 8'h22 ? 8'h00 : 8'hfe, d);
      end
      cmp("cfg staged", {24'h0064bc, 24'h000800, 12'h005}, active_cfg_out);
      host_u.soft_reset();
      cmp("soft reset pulse", 1'b1, soft_reset_out);
      repeat (2) @(negedge clk_in);
      cmp("soft reset end", 1'b0, soft_reset_out);
      cmp("cfg applied", {24'hfefefe, 24'hfefefe, 12'hefe}, active_cfg_out);
   endtask : t_write
   task t_update;
      host_u.wr(8'h25, 8'h01);
      cmp("snapshot pulse", 1'b1, snapshot_out);
      host_u.rd(8'h25, d);
      cmp("busy", 8'h01, d);
      cmp("snapshot end", 1'b0, snapshot_out);
      repeat (2) @(negedge clk_in);
      host_u.rd(8'h25, d);
      cmp("idle", 8'h00, d);
   endtask : t_update
   // VSB interval 3, QAM interval 2, threshold 1; equal count must not trip
   task t_mon;
      logic [7:0] v [10] = '{8'h03, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
      foreach (v[i])
         host_u.wr(a[i], v[i]);
      host_u.soft_reset();
      for (int r = 0; r < 4; r++)
      begin
         qam_mode_in = r[1];
         for (int b = 0; b < (r[1] ? 2 : 3); b++)
         begin
            @(negedge clk_in);
            rs_block_in = 1'b1;
            seg_error_in = (b < (r[0] ? 1 : 2));
            @(negedge clk_in);
            rs_block_in = 1'b0;
            seg_error_in = 1'b0;
         end
         host_u.poll();
         host_u.rd(8'h25, d);
         cmp("update done", 8'h00, d);
         host_u.rd(8'h26, d);
         cmp("over bit", r[0] ? 8'h00 : 8'h08, d);
      end
   endtask : t_mon
   // A reset in mid-run must drop both staged and active settings
   task t_midreset;
      host_u.wr(8'h1b, 8'hff);
      @(negedge clk_in);
      resetn_in = 1'b0;
      repeat (2) @(negedge clk_in);
      resetn_in = 1'b1;
      cmp("cfg after reset", {24'h0064bc, 24'h000800, 12'h005}, active_cfg_out);
      host_u.rd(8'h1b, d);
      cmp("vsb byte0 after reset", 8'hbc, d);
   endtask : t_midreset
   initial
   begin
      repeat (8) @(posedge clk_in);
      @(negedge clk_in);
      resetn_in = 1'b1;
      t_reset();
      t_write();
      t_update();
      t_mon();
      t_midreset();
      tally_and_finish();
   end
   initial
   begin
      repeat (3000) @(posedge clk_in);
      bad_count++;
      tally_and_finish();
   end
endmodule : fec_error_monitor_regs_tb
`default_nettype wire
